// [aoc_pkg.sv]
// Purpose: shared constants and types for the aux output and shutdown control
// Assumes: 8-bit instruction and data frames on a two-wire serial slave link
// Notes:   bit positions count from the lsb of the instruction byte
package aoc_pkg;

  localparam logic [4:0] ADDR_FIXED = 5'h0B;
  localparam logic [3:0] BIT_ZERO   = 4'h0;
  localparam logic [3:0] BIT_ONE    = 4'h1;
  localparam logic [3:0] BYTE_LAST  = 4'h7;
  localparam logic [3:0] ACK_SLOT   = 4'h8;

  localparam int INS_CHAN = 7;
  localparam int INS_RS   = 6;
  localparam int INS_SD   = 5;
  localparam int INS_AUX2 = 4;
  localparam int INS_AUX1 = 3;

  localparam logic [7:0] WIPER_MID = 8'h80;
  localparam logic       AUX_RST   = 1'b0;
  localparam logic       PIN_N_RST = 1'b1;

  typedef enum logic [3:0] {
    PH_ADDR   = 4'h1,
    PH_INSTR  = 4'h2,
    PH_DATA   = 4'h4,
    PH_IGNORE = 4'h8
  } aoc_phase_t;

  typedef struct packed {
    logic       is_data;
    logic [7:0] value;
  } aoc_event_t;

  typedef struct packed {
    aoc_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic       ack;
    logic       start_seen;
    aoc_event_t ev;
    logic       ev_tgl;
  } aoc_link_t;

  typedef struct packed {
    logic            link_rst;
    logic            aux_first;
    logic            aux_second;
    logic            chan;
    logic [1:0]      soft_sd;
    logic [1:0][7:0] wiper;
    logic [1:0]      chan_shutdown_input_n;
  } aoc_core_t;

  localparam aoc_event_t EV_RST = '{is_data: 1'b0, value: 8'h00};

  localparam aoc_link_t LINK_RST = '{phase: PH_IGNORE, bitcnt: BIT_ZERO, shreg: 8'h00,
                                     ack: 1'b0, start_seen: 1'b0, ev: EV_RST, ev_tgl: 1'b0};

  localparam aoc_core_t CORE_RST = '{link_rst: 1'b1, aux_first: AUX_RST, aux_second: AUX_RST,
                                     chan: 1'b0, soft_sd: 2'h0, wiper: {WIPER_MID, WIPER_MID},
                                     chan_shutdown_input_n: 2'h0};

endpackage

// [aoc_sync3.sv]
// Purpose: three-stage synchroniser with agreement filter
// Assumes: d_in is asynchronous to clk_in
// Notes:   output moves only once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module aoc_sync3 #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } aoc_sync_t;

  aoc_sync_t st;
  aoc_sync_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = d_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // per bit: follow stage three only where two and three agree
    next_st.q  = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.q);
    if (rst_in) begin
      next_st.q = RST_VAL;
    end
  end

  always_ff @(posedge clk_in) begin
    st <= next_st;
  end

  assign q_out = st.q;
endmodule
`default_nettype wire

// [aoc_evt_rx.sv]
// Purpose: receive side of a toggle handshake carrying one event word
// Assumes: word_in is held stable from before the toggle flips until long after
// Notes:   one-cycle valid per toggle change; word captured in the same cycle
`timescale 1ns/100ps
`default_nettype none
module aoc_evt_rx (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire logic               tgl_in,
  input  wire aoc_pkg::aoc_event_t word_in,
  output logic                    valid_out,
  output aoc_pkg::aoc_event_t     word_out
);
  import aoc_pkg::*;

  typedef struct packed {
    logic       last;
    logic       valid;
    aoc_event_t word;
  } aoc_rx_t;

  aoc_rx_t st;
  aoc_rx_t next_st;
  logic    tgl_sync;

  aoc_sync3 #(.W(1), .RST_VAL(1'b0)) u_tgl (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (tgl_in),
    .q_out  (tgl_sync)
  );

  always_comb begin
    next_st       = st;
    next_st.last  = tgl_sync;
    next_st.valid = tgl_sync != st.last;
    // word is quiet here: the far side wrote it on the same edge as the toggle, three sync stages back
    if (tgl_sync != st.last) begin
      next_st.word = word_in;
    end
    if (rst_in) begin
      next_st = '{last: 1'b0, valid: 1'b0, word: EV_RST};
    end
  end

  always_ff @(posedge clk_in) begin
    st <= next_st;
  end

  assign valid_out = st.valid;
  assign word_out  = st.word;
endmodule
`default_nettype wire

// [aoc_aux_shutdown_input_n_ctrl.sv]
// Purpose: serial slave instruction decode driving aux outputs and channel shutdown
// Assumes: scl_in is the link clock; sda is open drain, split into in/out/enable
// Notes:   link logic runs on scl and sda edges; settings live on mclk_in
//
// Contract
// - both aux outputs come up low after reset, before any command
// - aux output levels are taken from their bits of the instruction byte
// - address plus instruction with stop updates aux outputs, wiper untouched
// - repeated start without stop still accepts an instruction and applies outputs
// - shutdown enters on low shutdown pin or on a set soft shutdown bit
// - soft-shutdown channel keeps its setting and restores on the next command
// - bus programming stays accepted and stored while the pin holds shutdown
// - aux output one high on the tied pin releases shutdown, latest setting applies
// - instruction bits msb first: channel, midscale, soft shutdown, aux two, aux one
// - soft shutdown bit acts as the pin does, pin active low
// - answer only address with fixed upper five bits and strap-matched low two
`timescale 1ns/100ps
`default_nettype none
module aoc_aux_shutdown_input_n_ctrl (
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        shutdown_input_n_in,
  input  wire logic        address_strap_low_in,
  input  wire logic        address_strap_high_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  output logic             aux_logic_out_first_out,
  output logic             aux_logic_out_second_out,
  output logic [1:0]       channel_shutdown_out,
  output logic [1:0][7:0]  wiper_setting_register_out
);
  import aoc_pkg::*;

  aoc_core_t  core;
  aoc_core_t  next_core;
  aoc_link_t  lk;
  aoc_link_t  next_lk;
  logic       start_tgl;
  logic       oe;
  logic       sda_low;
  logic [1:0] strap;
  logic [7:0] byte_now;
  logic       ev_valid;
  aoc_event_t ev_word;
  logic       pin_n_sync;
  logic       ch;

  ////////////////////////////////////////////////////////////////////////////
  // link side: start detect, bit shifter, acknowledge

  // sda falling while scl high marks a start; flop kept on its own edge
  always_ff @(negedge sda_in or posedge core.link_rst) begin
    if (core.link_rst) begin
      start_tgl <= 1'b0;
    end else if (scl_in) begin
      start_tgl <= ~start_tgl;
    end
  end

  // straps are pins: synchronised on the link clock, settled before bit eight
  aoc_sync3 #(.W(2), .RST_VAL(2'h0)) u_strap (
    .clk_in (scl_in),
    .rst_in (core.link_rst),
    .d_in   ({address_strap_high_in, address_strap_low_in}),
    .q_out  (strap)
  );

  always_comb begin
    next_lk  = lk;
    byte_now = {lk.shreg[6:0], sda_in};
    if (lk.start_seen != start_tgl) begin
      // any start, with or without a stop before it, begins a new address
      next_lk.start_seen = start_tgl;
      next_lk.shreg      = {7'h00, sda_in};
      next_lk.bitcnt     = BIT_ONE;
      next_lk.phase      = PH_ADDR;
      next_lk.ack        = 1'b0;
    end else if (lk.bitcnt == ACK_SLOT) begin
      next_lk.bitcnt = BIT_ZERO;
      next_lk.ack    = 1'b0;
    end else begin
      next_lk.shreg  = byte_now;
      next_lk.bitcnt = lk.bitcnt + BIT_ONE;
      if (lk.bitcnt == BYTE_LAST) begin
        case (lk.phase)
          PH_ADDR: begin
            // reads are not served here, so only a write address is answered
            if (byte_now[7:1] == {ADDR_FIXED, strap} && !byte_now[0]) begin
              next_lk.ack   = 1'b1;
              next_lk.phase = PH_INSTR;
            end else begin
              next_lk.phase = PH_IGNORE;
            end
          end
          PH_INSTR: begin
            // instruction acts at its own ack; no data byte or stop needed
            next_lk.ack    = 1'b1;
            next_lk.ev     = '{is_data: 1'b0, value: byte_now};
            next_lk.ev_tgl = ~lk.ev_tgl;
            next_lk.phase  = PH_DATA;
          end
          PH_DATA: begin
            next_lk.ack    = 1'b1;
            next_lk.ev     = '{is_data: 1'b1, value: byte_now};
            next_lk.ev_tgl = ~lk.ev_tgl;
          end
          PH_IGNORE: begin
            next_lk.ack = 1'b0;
          end
          default: begin
            next_lk.phase = PH_IGNORE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge scl_in or posedge core.link_rst) begin
    if (core.link_rst) begin
      lk <= LINK_RST;
    end else begin
      lk <= next_lk;
    end
  end

  // ack pulled on the falling edge so sda is steady for the whole high phase
  always_ff @(negedge scl_in or posedge core.link_rst) begin
    if (core.link_rst) begin
      oe      <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      oe      <= lk.ack && (lk.bitcnt == ACK_SLOT);
      sda_low <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // crossings into the mclk domain

  aoc_evt_rx u_evt (
    .clk_in    (mclk_in),
    .rst_in    (reset_in),
    .tgl_in    (lk.ev_tgl),
    .word_in   (lk.ev),
    .valid_out (ev_valid),
    .word_out  (ev_word)
  );

  aoc_sync3 #(.W(1), .RST_VAL(PIN_N_RST)) u_shutdown_input_n (
    .clk_in (mclk_in),
    .rst_in (reset_in),
    .d_in   (shutdown_input_n_in),
    .q_out  (pin_n_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // settings: aux latches, wipers, shutdown

  always_comb begin
    next_core          = core;
    ch                 = ev_word.value[INS_CHAN];
    next_core.link_rst = reset_in;
    if (ev_valid) begin
      if (!ev_word.is_data) begin
        next_core.chan       = ch;
        next_core.aux_first  = ev_word.value[INS_AUX1];
        next_core.aux_second = ev_word.value[INS_AUX2];
        if (ev_word.value[INS_RS]) begin
          next_core.wiper[ch] = WIPER_MID;
        end
        // wiper values stay stored; shutdown shows only on channel_shutdown_out, wiper outputs unmasked
        if (ev_word.value[INS_SD]) begin
          next_core.soft_sd[ch] = 1'b1;
        end else begin
          next_core.soft_sd = 2'h0;
        end
      end else begin
        // stored even while the pin holds shutdown
        next_core.wiper[core.chan] = ev_word.value;
      end
    end
    // pin and soft bit share one path; pin active low
    next_core.chan_shutdown_input_n = {2{~pin_n_sync}} | next_core.soft_sd;
    if (reset_in) begin
      next_core = CORE_RST;
    end
  end

  always_ff @(posedge mclk_in) begin
    core <= next_core;
  end

  assign sda_out                    = sda_low;
  assign sda_oe_out                 = oe;
  assign aux_logic_out_first_out    = core.aux_first;
  assign aux_logic_out_second_out   = core.aux_second;
  assign channel_shutdown_out       = core.chan_shutdown_input_n;
  assign wiper_setting_register_out = core.wiper;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_ack_slot;
    lk.bitcnt == ACK_SLOT && lk.ack;
  endsequence

  sequence s_ack_then_release;
    sda_oe_out ##1 !sda_oe_out;
  endsequence

  // pin low long enough to cross three stages, agreement and the output flop
  sequence s_pin_low_held;
    $fell(shutdown_input_n_in) ##1 !shutdown_input_n_in [*4];
  endsequence

  a_aux_reset_low: assert property (
    @(posedge mclk_in) reset_in |=> !aux_logic_out_first_out && !aux_logic_out_second_out)
    else $error("aux outputs not low after reset");

  a_aux_from_instr: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    ev_valid && !ev_word.is_data |=>
      aux_logic_out_first_out == $past(ev_word.value[INS_AUX1]) &&
      aux_logic_out_second_out == $past(ev_word.value[INS_AUX2]))
    else $error("aux outputs do not follow instruction bits");

  a_wiper_kept_instr: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    ev_valid && !ev_word.is_data && !ev_word.value[INS_RS] |=>
      $stable(wiper_setting_register_out))
    else $error("instruction without data changed a wiper");

  a_aux_hold_idle: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    !ev_valid ##1 !reset_in |->
      $stable(aux_logic_out_first_out) && $stable(aux_logic_out_second_out))
    else $error("aux outputs moved without an instruction");

  a_soft_sd_entry: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    ev_valid && !ev_word.is_data && ev_word.value[INS_SD] |=>
      channel_shutdown_out[$past(ch)])
    else $error("soft shutdown bit did not shut the channel");

  a_pin_shutdown_input_n_entry: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    !pin_n_sync |=> channel_shutdown_out == 2'h3)
    else $error("shutdown pin low did not shut both channels");

  a_restore_on_cmd: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    ev_valid && !ev_word.is_data && !ev_word.value[INS_SD] && !ev_word.value[INS_RS] && pin_n_sync
      |=> channel_shutdown_out == 2'h0 && $stable(wiper_setting_register_out))
    else $error("new command did not restore the prior wiper");

  a_store_in_shutdown_input_n: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    ev_valid && ev_word.is_data |=>
      wiper_setting_register_out[$past(core.chan)] == $past(ev_word.value))
    else $error("data byte not stored");

  a_release_on_high: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    pin_n_sync && core.soft_sd == 2'h0 && !ev_valid |=> channel_shutdown_out == 2'h0)
    else $error("shutdown not released with pin high");

  a_restart_addr: assert property (
    @(posedge scl_in) disable iff (core.link_rst)
    lk.start_seen != start_tgl |=> lk.phase == PH_ADDR && lk.bitcnt == BIT_ONE)
    else $error("start did not restart address phase");

  a_ack_window: assert property (
    @(posedge scl_in) disable iff (core.link_rst)
    s_ack_slot |-> s_ack_then_release)
    else $error("ack not driven for exactly the ninth bit");

  a_nack_foreign: assert property (
    @(posedge scl_in) disable iff (core.link_rst)
    lk.bitcnt == ACK_SLOT && !lk.ack |-> !sda_oe_out)
    else $error("sda driven for an unanswered byte");

  a_pin_sync_lag: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    s_pin_low_held |=> channel_shutdown_out == 2'h3)
    else $error("shutdown pin low not seen within five clocks");

  a_midscale_load: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    ev_valid && !ev_word.is_data && ev_word.value[INS_RS] |=>
      wiper_setting_register_out[$past(ch)] == WIPER_MID)
    else $error("midscale bit did not centre the selected wiper");

  a_soft_sd_clear: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    ev_valid && !ev_word.is_data && !ev_word.value[INS_SD] |=> core.soft_sd == 2'h0)
    else $error("command without soft shutdown left a flag set");

  a_store_other_kept: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    ev_valid && ev_word.is_data |=>
      wiper_setting_register_out[!$past(core.chan)] == $past(wiper_setting_register_out[!core.chan]))
    else $error("data byte disturbed the other wiper");
endmodule
`default_nettype wire

// [aoc_bus_master.sv]
// Purpose: behavioural serial bus master for the aux output block
// Assumes: open-drain wires with pull-ups, scl period 64 ns
// Notes:   scl stands high between frames ended by a stop, low before a repeated start; master never stretches
`timescale 1ns/100ps
`default_nettype none
module aoc_bus_master (
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////
  // also a repeated start when entered with scl low, no stop needed
  task automatic start_cond();
    sda_oe_out = 1'b0;
    #16 scl_out = 1'b1;
    #16 sda_oe_out = 1'b1;
    #32 scl_out = 1'b0;
  endtask
  // data moves only while scl low
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_oe_out = ~b[i];
      #16 scl_out = 1'b1;
      #32 scl_out = 1'b0;
      #16;
    end
    sda_oe_out = 1'b0;
    #16 scl_out = 1'b1;
    #16 ack = ~sda_in;
    #16 scl_out = 1'b0;
    #16;
  endtask
  task automatic stop_cond();
    sda_oe_out = 1'b1;
    #16 scl_out = 1'b1;
    #16 sda_oe_out = 1'b0;
    #32;
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Purpose: self-checking bench for the aux output and shutdown block
// Assumes: settings land within 10 mclk after the last scl edge
// Notes:   random straps, addresses and instructions from a fixed lfsr
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import aoc_pkg::*;
  logic            mclk_in;
  logic            reset_in;
  logic            pin_drv;
  logic            tie_aux;
  logic            strap_lo;
  logic            strap_hi;
  logic            scl;
  logic            m_oe;
  logic            d_sda;
  logic            d_oe;
  logic            sda_wire;
  logic            pin_n;
  logic            aux1;
  logic            aux2;
  logic [1:0]      shutdown_input_n;
  logic [1:0][7:0] wip;
  logic            e_aux1;
  logic            e_aux2;
  logic            e_chan;
  logic [1:0]      e_soft;
  logic [1:0][7:0] e_wip;
  logic [7:0]      rnd;
  logic [7:0]      ins;
  logic [6:0]      addr;
  logic            ack_rd;
  int              err_count = 0;
  int              checks = 0;
  int              cycles = 0;
  // pull-up on sda; tie_aux wires aux output one onto the shutdown pin
  assign sda_wire = ~(m_oe | (d_oe & ~d_sda));
  assign pin_n = tie_aux ? aux1 : pin_drv;
  aoc_aux_shutdown_input_n_ctrl u_aoc_aux_shutdown_input_n_ctrl (
    .mclk_in                    (mclk_in),
    .reset_in                   (reset_in),
    .scl_in                     (scl),
    .sda_in                     (sda_wire),
    .shutdown_input_n_in        (pin_n),
    .address_strap_low_in       (strap_lo),
    .address_strap_high_in      (strap_hi),
    .sda_out                    (d_sda),
    .sda_oe_out                 (d_oe),
    .aux_logic_out_first_out    (aux1),
    .aux_logic_out_second_out   (aux2),
    .channel_shutdown_out       (shutdown_input_n),
    .wiper_setting_register_out (wip)
  );
  aoc_bus_master u_aoc_bus_master (
    .sda_in     (sda_wire),
    .scl_out    (scl),
    .sda_oe_out (m_oe)
  );
  ////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [6:0] good_addr();
    return {ADDR_FIXED, strap_hi, strap_lo};
  endfunction
  function automatic logic [19:0] exp_vec();
    logic pin;
    pin = tie_aux ? e_aux1 : pin_drv;
    return {e_aux2, e_aux1, {2{~pin}} | e_soft, e_wip};
  endfunction
  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_ack(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t ack got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic settle_check();
    // looked at on the falling edge, clear of the edge that launches outputs
    repeat (10) @(negedge mclk_in);
    cmp({aux2, aux1, shutdown_input_n, wip}, exp_vec());
  endtask
  // instruction byte is sent even when unacked, to prove it is ignored
  task automatic xfer(input logic [6:0] a, input logic [7:0] i, input logic [7:0] d,
                      input logic with_data, input logic do_stop);
    logic ack;
    logic hit;
    hit = (a === good_addr());
    u_aoc_bus_master.start_cond();
    u_aoc_bus_master.put_byte({a, 1'b0}, ack);
    cmp_ack(ack, hit);
    u_aoc_bus_master.put_byte(i, ack);
    cmp_ack(ack, hit);
    if (hit) begin
      e_aux2 = i[INS_AUX2];
      e_aux1 = i[INS_AUX1];
      e_chan = i[INS_CHAN];
      if (i[INS_RS]) e_wip[e_chan] = WIPER_MID;
      if (i[INS_SD]) e_soft[e_chan] = 1'b1;
      else e_soft = 2'b00;
      if (with_data) begin
        u_aoc_bus_master.put_byte(d, ack);
        cmp_ack(ack, 1'b1);
        e_wip[e_chan] = d;
      end
    end
    if (do_stop) u_aoc_bus_master.stop_cond();
    settle_check();
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    reset_in = 1'b1;
    pin_drv = 1'b1;
    tie_aux = 1'b0;
    strap_lo = 1'b0;
    strap_hi = 1'b1;
    rnd = 8'h5c;
    {e_aux1, e_aux2, e_chan, e_soft} = '0;
    e_wip = {WIPER_MID, WIPER_MID};
    repeat (8) @(posedge mclk_in);
    @(negedge mclk_in) reset_in = 1'b0;
    settle_check();
    xfer(good_addr(), 8'h00, 8'h3c, 1'b1, 1'b1);
    xfer(good_addr(), 8'h18, 8'h00, 1'b0, 1'b0);
    xfer(good_addr(), 8'h08, 8'h00, 1'b0, 1'b1);
    xfer(good_addr(), 8'h97, 8'h00, 1'b0, 1'b1);
    for (int n = 0; n < 24; n++) begin
      rnd = lfsr(rnd);
      @(negedge mclk_in);
      {strap_hi, strap_lo} = rnd[1:0];
      ins = lfsr(rnd);
      rnd = lfsr(ins);
      addr = good_addr() ^ ((rnd[6:5] == 2'b00) ? 7'h01 << rnd[4:3] : 7'h00);
      xfer(addr, ins, rnd, rnd[7], rnd[2] | n[0]);
    end
    xfer(good_addr(), 8'hc0, 8'h00, 1'b0, 1'b1);
    // read requests are refused: no ack, settings untouched
    u_aoc_bus_master.start_cond();
    u_aoc_bus_master.put_byte({good_addr(), 1'b1}, ack_rd);
    cmp_ack(ack_rd, 1'b0);
    u_aoc_bus_master.stop_cond();
    settle_check();
    xfer(good_addr(), 8'h00, 8'h00, 1'b0, 1'b1);
    @(negedge mclk_in) pin_drv = 1'b0;
    settle_check();
    xfer(good_addr(), 8'h98, 8'ha5, 1'b1, 1'b1);
    @(negedge mclk_in) pin_drv = 1'b1;
    settle_check();
    xfer(good_addr(), 8'h20, 8'h11, 1'b1, 1'b1);
    xfer(good_addr(), 8'h00, 8'h00, 1'b0, 1'b1);
    @(negedge mclk_in) tie_aux = 1'b1;
    settle_check();
    xfer(good_addr(), 8'h80, 8'h77, 1'b1, 1'b1);
    xfer(good_addr(), 8'h08, 8'h00, 1'b0, 1'b1);
    xfer(good_addr(), 8'h00, 8'h00, 1'b0, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
